// [rsbe_pkg.sv]
// Constants, types and encodings for the rotate / subtract / bank execution unit
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
package rsbe_pkg;

    localparam logic [7:0] OP_RLC_R   = 8'h10;
    localparam logic [7:0] OP_RLC_IR  = 8'h11;
    localparam logic [7:0] OP_RR_R    = 8'hE0;
    localparam logic [7:0] OP_RR_IR   = 8'hE1;
    localparam logic [7:0] OP_RRC_R   = 8'hC0;
    localparam logic [7:0] OP_RRC_IR  = 8'hC1;
    localparam logic [7:0] OP_SBC_WW  = 8'h32;
    localparam logic [7:0] OP_SBC_WI  = 8'h33;
    localparam logic [7:0] OP_SBC_RR  = 8'h34;
    localparam logic [7:0] OP_SBC_RI  = 8'h35;
    localparam logic [7:0] OP_SBC_IM  = 8'h36;
    localparam logic [7:0] OP_SB_LOW  = 8'h4F;
    localparam logic [7:0] OP_SB_HIGH = 8'h5F;

    localparam logic [2:0] CYC_SHORT  = 3'h4;
    localparam logic [2:0] CYC_LONG   = 3'h6;

    localparam int FLG_C    = 7;
    localparam int FLG_Z    = 6;
    localparam int FLG_S    = 5;
    localparam int FLG_V    = 4;
    localparam int FLG_D    = 3;
    localparam int FLG_H    = 2;
    localparam int FLG_BANK = 0;
    localparam logic [7:0] FLAGS_RST  = 8'h00;

    localparam logic [3:0] WREG_HI    = 4'hC;

    localparam logic [7:0] REG_FLAGS  = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h01;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] op1;
        logic [7:0] op2;
    } rsbe_instr_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       we;
        logic       re;
    } rsbe_rf_req_t;

    typedef enum logic [2:0] {ALU_RLC, ALU_RR, ALU_RRC, ALU_SBC, ALU_SBLO, ALU_SBHI} rsbe_alu_t;

    typedef enum logic [2:0] {ST_IDLE, ST_PTR, ST_SRC, ST_DST, ST_WAIT} rsbe_state_t;

endpackage : rsbe_pkg

// [rsbe_exec.sv]
// Execution unit for rotates through carry, plain rotate right, subtract with borrow and bank select
//
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns
module rsbe_exec
    import rsbe_pkg::*;
#(
    parameter bit HIGH_BANK_PRESENT = 1'b1
) (
    input  wire logic         clk_in,
    input  wire logic         rst_b_in,
    input  wire logic         start_in,
    input  wire rsbe_instr_t  instr_in,
    input  wire logic [7:0]   rf_rdata_in,
    input  wire logic [7:0]   reg_addr_in,
    input  wire logic [7:0]   reg_wdata_in,
    input  wire logic         reg_wr_in,
    input  wire logic         reg_rd_in,
    output rsbe_rf_req_t      rf_req_out,
    output logic              busy_out,
    output logic              done_out,
    output logic [7:0]        flags_out,
    output logic [7:0]        reg_rdata_out
);

    //////////////////////////////////////////////////////////////////////////
    // Decode of the instruction offered with start
    rsbe_state_t state_r;
    logic        dec_ok;
    rsbe_alu_t   dec_alu;
    logic [2:0]  dec_len;
    logic        dec_ptr;
    logic        dec_ptr_dst;
    logic [7:0]  dec_ptr_addr;
    logic        dec_src_mem;
    logic [7:0]  dec_src_addr;
    logic [7:0]  dec_src_val;
    logic        dec_dst_rd;
    logic [7:0]  dec_dst_addr;
    logic        take;

    always_comb begin
        dec_ok       = 1'b1;
        dec_alu      = ALU_SBC;
        dec_len      = CYC_LONG;
        dec_ptr      = 1'b0;
        dec_ptr_dst  = 1'b0;
        dec_ptr_addr = instr_in.op1;
        dec_src_mem  = 1'b0;
        dec_src_addr = instr_in.op1;
        dec_src_val  = instr_in.op2;
        dec_dst_rd   = 1'b1;
        dec_dst_addr = instr_in.op1;
        unique case (instr_in.opcode)
            OP_RLC_R, OP_RLC_IR, OP_RR_R, OP_RR_IR, OP_RRC_R, OP_RRC_IR: begin
                // Odd opcode of each pair is the indirect form
                dec_len     = CYC_SHORT;
                dec_ptr     = instr_in.opcode[0];
                dec_ptr_dst = 1'b1;
                if (instr_in.opcode[7:1] == OP_RLC_R[7:1]) begin
                    dec_alu = ALU_RLC;
                end else if (instr_in.opcode[7:1] == OP_RR_R[7:1]) begin
                    dec_alu = ALU_RR;
                end else begin
                    dec_alu = ALU_RRC;
                end
            end
            OP_SBC_WW: begin
                dec_len      = CYC_SHORT;
                dec_src_mem  = 1'b1;
                dec_src_addr = {WREG_HI, instr_in.op1[3:0]};
                dec_dst_addr = {WREG_HI, instr_in.op1[7:4]};
            end
            OP_SBC_WI: begin
                dec_ptr      = 1'b1;
                dec_ptr_addr = {WREG_HI, instr_in.op1[3:0]};
                dec_src_mem  = 1'b1;
                dec_dst_addr = {WREG_HI, instr_in.op1[7:4]};
            end
            OP_SBC_RR: begin
                dec_src_mem  = 1'b1;
                dec_dst_addr = instr_in.op2;
            end
            OP_SBC_RI: begin
                dec_ptr      = 1'b1;
                dec_src_mem  = 1'b1;
                dec_dst_addr = instr_in.op2;
            end
            OP_SBC_IM: begin
                dec_src_val = instr_in.op2;
            end
            OP_SB_LOW, OP_SB_HIGH: begin
                dec_alu    = (instr_in.opcode == OP_SB_LOW) ? ALU_SBLO : ALU_SBHI;
                dec_len    = CYC_SHORT;
                dec_dst_rd = 1'b0;
            end
            default: begin
                // Unknown opcodes belong to other units and are not taken
                dec_ok = 1'b0;
            end
        endcase
    end

    assign take = start_in && dec_ok && (state_r == ST_IDLE);

    //////////////////////////////////////////////////////////////////////////
    // Sequencer: register file reads, cycle count and commit
    rsbe_alu_t  alu_r;
    logic [2:0] len_r;
    logic [2:0] cnt_r;
    logic       ph_r;
    logic       ptr_dst_r;
    logic       src_mem_r;
    logic       dst_rd_r;
    logic [7:0] src_addr_r;
    logic [7:0] dst_addr_r;
    logic [7:0] src_val_r;
    logic [7:0] dst_val_r;
    logic       commit;
    logic [7:0] dst_opnd;
    logic [7:0] alu_res;

    // Commit waits for the fixed count even when reads finish early
    assign commit   = (state_r != ST_IDLE) && (cnt_r == len_r);
    assign dst_opnd = (state_r == ST_DST) ? rf_rdata_in : dst_val_r;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_r    <= ST_IDLE;
            alu_r      <= ALU_SBC;
            len_r      <= CYC_SHORT;
            cnt_r      <= 3'h0;
            ph_r       <= 1'b0;
            ptr_dst_r  <= 1'b0;
            src_mem_r  <= 1'b0;
            dst_rd_r   <= 1'b0;
            src_addr_r <= 8'h00;
            dst_addr_r <= 8'h00;
            src_val_r  <= 8'h00;
            dst_val_r  <= 8'h00;
            rf_req_out <= '0;
            busy_out   <= 1'b0;
            done_out   <= 1'b0;
        end else begin
            rf_req_out.re <= 1'b0;
            rf_req_out.we <= 1'b0;
            done_out      <= 1'b0;
            if (state_r != ST_IDLE) begin
                cnt_r <= cnt_r + 3'h1;
            end
            if (commit) begin
                // Only the destination is ever written; bank selects write nothing
                rf_req_out.we    <= dst_rd_r;
                rf_req_out.addr  <= dst_addr_r;
                rf_req_out.wdata <= alu_res;
                done_out         <= 1'b1;
                busy_out         <= 1'b0;
                state_r          <= ST_IDLE;
            end else begin
                unique case (state_r)
                    ST_IDLE: begin
                        if (take) begin
                            alu_r      <= dec_alu;
                            len_r      <= dec_len;
                            cnt_r      <= 3'h1;
                            ph_r       <= 1'b0;
                            ptr_dst_r  <= dec_ptr_dst;
                            src_mem_r  <= dec_src_mem;
                            dst_rd_r   <= dec_dst_rd;
                            src_addr_r <= dec_src_addr;
                            dst_addr_r <= dec_dst_addr;
                            src_val_r  <= dec_src_val;
                            busy_out   <= 1'b1;
                            rf_req_out.re <= dec_ptr || dec_src_mem || dec_dst_rd;
                            if (dec_ptr) begin
                                rf_req_out.addr <= dec_ptr_addr;
                                state_r         <= ST_PTR;
                            end else if (dec_src_mem) begin
                                rf_req_out.addr <= dec_src_addr;
                                state_r         <= ST_SRC;
                            end else if (dec_dst_rd) begin
                                rf_req_out.addr <= dec_dst_addr;
                                state_r         <= ST_DST;
                            end else begin
                                state_r <= ST_WAIT;
                            end
                        end
                    end
                    ST_PTR: begin
                        ph_r <= ~ph_r;
                        if (ph_r) begin
                            // Pointer content becomes the operand address
                            rf_req_out.re   <= 1'b1;
                            rf_req_out.addr <= rf_rdata_in;
                            if (ptr_dst_r) begin
                                dst_addr_r <= rf_rdata_in;
                                state_r    <= ST_DST;
                            end else begin
                                src_addr_r <= rf_rdata_in;
                                state_r    <= ST_SRC;
                            end
                        end
                    end
                    ST_SRC: begin
                        ph_r <= ~ph_r;
                        if (ph_r) begin
                            src_val_r       <= rf_rdata_in;
                            rf_req_out.re   <= 1'b1;
                            rf_req_out.addr <= dst_addr_r;
                            state_r         <= ST_DST;
                        end
                    end
                    ST_DST: begin
                        ph_r <= ~ph_r;
                        if (ph_r) begin
                            dst_val_r <= rf_rdata_in;
                            state_r   <= ST_WAIT;
                        end
                    end
                    ST_WAIT: begin
                        state_r <= ST_WAIT;
                    end
                endcase
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Arithmetic and flag computation
    logic [7:0] flags_nxt;
    logic [8:0] sum9;
    logic [4:0] sum5;
    logic       cin;

    assign cin = flags_out[FLG_C];

    always_comb begin
        // Subtraction as add of the inverted source plus inverted borrow
        sum9      = {1'b0, dst_opnd} + {1'b0, ~src_val_r} + {8'h00, ~cin};
        sum5      = {1'b0, dst_opnd[3:0]} + {1'b0, ~src_val_r[3:0]} + {4'h0, ~cin};
        alu_res   = dst_opnd;
        flags_nxt = flags_out;
        unique case (alu_r)
            ALU_RLC: begin
                alu_res          = {dst_opnd[6:0], cin};
                flags_nxt[FLG_C] = dst_opnd[7];
            end
            ALU_RR: begin
                alu_res          = {dst_opnd[0], dst_opnd[7:1]};
                flags_nxt[FLG_C] = dst_opnd[0];
            end
            ALU_RRC: begin
                alu_res          = {cin, dst_opnd[7:1]};
                flags_nxt[FLG_C] = dst_opnd[0];
            end
            ALU_SBC: begin
                alu_res          = sum9[7:0];
                flags_nxt[FLG_C] = ~sum9[8];
                flags_nxt[FLG_V] = (dst_opnd[7] != src_val_r[7]) && (sum9[7] == src_val_r[7]);
                flags_nxt[FLG_D] = 1'b1;
                flags_nxt[FLG_H] = ~sum5[4];
            end
            ALU_SBLO: begin
                flags_nxt[FLG_BANK] = 1'b0;
            end
            ALU_SBHI: begin
                // No bank-1 storage lives here, so absence changes nothing
                flags_nxt[FLG_BANK] = 1'b1;
            end
        endcase
        if (alu_r != ALU_SBLO && alu_r != ALU_SBHI) begin
            flags_nxt[FLG_Z] = (alu_res == 8'h00);
            flags_nxt[FLG_S] = alu_res[7];
        end
        if (alu_r == ALU_RLC || alu_r == ALU_RR || alu_r == ALU_RRC) begin
            flags_nxt[FLG_V] = dst_opnd[7] ^ alu_res[7];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Flags register; commit beats a software write in the same cycle
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            flags_out <= FLAGS_RST;
        end else if (commit) begin
            flags_out <= flags_nxt;
        end else if (reg_wr_in && reg_addr_in == REG_FLAGS) begin
            flags_out <= reg_wdata_in;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Register read port
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in && reg_addr_in == REG_FLAGS) begin
            reg_rdata_out <= flags_out;
        end else if (reg_rd_in && reg_addr_in == REG_STATUS) begin
            reg_rdata_out <= {busy_out, 4'h0, state_r};
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Checks
    logic [7:0] opnd_q;
    logic [7:0] src_q;
    logic [7:0] flags_q;
    logic [7:0] waddr_q;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            opnd_q  <= 8'h00;
            src_q   <= 8'h00;
            flags_q <= 8'h00;
            waddr_q <= 8'h00;
        end else begin
            opnd_q  <= dst_opnd;
            src_q   <= src_val_r;
            flags_q <= flags_out;
            waddr_q <= dst_addr_r;
        end
    end

    sequence s_take_short;
        take && (dec_len == CYC_SHORT);
    endsequence

    sequence s_take_long;
        take && (dec_len == CYC_LONG);
    endsequence

    sequence s_ptr_read;
        take && dec_ptr && dec_ptr_dst ##2 (state_r == ST_PTR) && ph_r;
    endsequence

    property p_short_len;
        @(posedge clk_in) disable iff (!rst_b_in)
        s_take_short |=> !done_out [*4] ##1 done_out;
    endproperty
    a_short_len: assert property (p_short_len) else $error("short op not done in 4 cycles");

    property p_long_len;
        @(posedge clk_in) disable iff (!rst_b_in)
        s_take_long |-> ##7 done_out && !busy_out;
    endproperty
    a_long_len: assert property (p_long_len) else $error("long op not done in 6 cycles");

    property p_ptr_dst;
        @(posedge clk_in) disable iff (!rst_b_in)
        s_ptr_read |=> rf_req_out.re && rf_req_out.addr == $past(rf_rdata_in) ##2 done_out && rf_req_out.we;
    endproperty
    a_ptr_dst: assert property (p_ptr_dst) else $error("indirect address not taken from pointer");

    property p_rlc;
        @(posedge clk_in) disable iff (!rst_b_in)
        done_out && alu_r == ALU_RLC |->
            flags_out[FLG_C] == opnd_q[7] && rf_req_out.wdata == {opnd_q[6:0], flags_q[FLG_C]};
    endproperty
    a_rlc: assert property (p_rlc) else $error("rotate left through carry wrong");

    property p_rr;
        @(posedge clk_in) disable iff (!rst_b_in)
        done_out && alu_r == ALU_RR |->
            flags_out[FLG_C] == opnd_q[0] && rf_req_out.wdata == {opnd_q[0], opnd_q[7:1]};
    endproperty
    a_rr: assert property (p_rr) else $error("plain rotate right wrong");

    property p_rrc;
        @(posedge clk_in) disable iff (!rst_b_in)
        done_out && alu_r == ALU_RRC |->
            flags_out[FLG_C] == opnd_q[0] && rf_req_out.wdata == {flags_q[FLG_C], opnd_q[7:1]};
    endproperty
    a_rrc: assert property (p_rrc) else $error("rotate right through carry wrong");

    property p_rot_flags;
        @(posedge clk_in) disable iff (!rst_b_in)
        done_out && (alu_r == ALU_RLC || alu_r == ALU_RR || alu_r == ALU_RRC) |->
            flags_out[FLG_Z] == (rf_req_out.wdata == 8'h00) && flags_out[FLG_S] == rf_req_out.wdata[7]
            && flags_out[FLG_V] == (opnd_q[7] ^ rf_req_out.wdata[7])
            && flags_out[FLG_D:FLG_H] == flags_q[FLG_D:FLG_H];
    endproperty
    a_rot_flags: assert property (p_rot_flags) else $error("rotate flags wrong");

    property p_sbc;
        @(posedge clk_in) disable iff (!rst_b_in)
        done_out && alu_r == ALU_SBC |->
            rf_req_out.wdata == opnd_q - src_q - {7'h00, flags_q[FLG_C]} && rf_req_out.addr == waddr_q
            && flags_out[FLG_C] == ({1'b0, src_q} + {8'h00, flags_q[FLG_C]} > {1'b0, opnd_q})
            && flags_out[FLG_D];
    endproperty
    a_sbc: assert property (p_sbc) else $error("subtract with borrow wrong");

    property p_bank;
        @(posedge clk_in) disable iff (!rst_b_in)
        done_out && (alu_r == ALU_SBLO || alu_r == ALU_SBHI) |->
            !rf_req_out.we && flags_out[7:1] == flags_q[7:1] && flags_out[FLG_BANK] == (alu_r == ALU_SBHI);
    endproperty
    a_bank: assert property (p_bank) else $error("bank select wrong");

    property p_we_only_done;
        @(posedge clk_in) disable iff (!rst_b_in)
        rf_req_out.we |-> done_out && $past(busy_out);
    endproperty
    a_we_only_done: assert property (p_we_only_done) else $error("write outside commit");

endmodule : rsbe_exec

// [rsbe_rf_model.sv]
// Register file model facing the execution unit
`timescale 1ns/1ns
module rsbe_rf_model
    import rsbe_pkg::*;
(
    input  wire logic         clk_in,
    input  wire rsbe_rf_req_t req_in,
    output logic [7:0]        rdata_out
);
    logic [7:0] mem [256];
    int         wr_count = 0;
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'h5A;
        end
    end
    // Data stand one cycle only; then the line toggles so stale data cannot pass
    always @(posedge clk_in) begin
        if (req_in.re) begin
            rdata_out <= mem[req_in.addr];
        end else begin
            rdata_out <= ~rdata_out;
        end
        if (req_in.we) begin
            mem[req_in.addr] <= req_in.wdata;
            wr_count <= wr_count + 1;
        end
    end
endmodule : rsbe_rf_model

// [rsbe_exec_test.sv]
// Self-checking bench for the rotate, subtract and bank select unit
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module rsbe_exec_test
    import rsbe_pkg::*;
;
    logic         clk_in;
    logic         rst_b_in;
    logic         start_in;
    rsbe_instr_t  instr_in;
    logic [7:0]   rf_rdata_in;
    logic [7:0]   reg_addr_in;
    logic [7:0]   reg_wdata_in;
    logic         reg_wr_in;
    logic         reg_rd_in;
    rsbe_rf_req_t rf_req_out;
    logic         busy_out;
    logic         done_out;
    logic [7:0]   flags_out;
    logic [7:0]   reg_rdata_out;
    logic [7:0]   rd_v;
    int           miscompares = 0;
    int           num_checks = 0;
    rsbe_exec rsbe_exec_inst (.clk_in(clk_in), .rst_b_in(rst_b_in), .start_in(start_in), .instr_in(instr_in),
        .rf_rdata_in(rf_rdata_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .rf_req_out(rf_req_out), .busy_out(busy_out), .done_out(done_out),
        .flags_out(flags_out), .reg_rdata_out(reg_rdata_out));
    rsbe_rf_model rsbe_rf_model_inst (.clk_in(clk_in), .req_in(rf_req_out), .rdata_out(rf_rdata_in));
    initial clk_in = 1'h0;
    always #4 clk_in = ~clk_in;
    ////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        {reg_addr_in, reg_wdata_in, reg_wr_in} <= {a, d, 1'h1};
        @(posedge clk_in);
        reg_wr_in <= 1'h0;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        {reg_addr_in, reg_rd_in} <= {a, 1'h1};
        @(posedge clk_in);
        reg_rd_in <= 1'h0;
        #1 d = reg_rdata_out;
    endtask : reg_rd
    function automatic logic [15:0] expect_op(input logic [7:0] op, d, s, f);
        logic [7:0] r;
        logic       c;
        logic [4:0] lo;
        logic [7:0] nf;
        nf = f;
        case (op)
            OP_RLC_R, OP_RLC_IR: {c, r} = {d, f[FLG_C]};
            OP_RR_R, OP_RR_IR:   {r, c} = {d[0], d[7:1], d[0]};
            OP_RRC_R, OP_RRC_IR: {r, c} = {f[FLG_C], d};
            default:             {c, r} = {1'h0, d} - {1'h0, s} - 9'(f[FLG_C]);
        endcase
        lo = {1'h0, d[3:0]} + {1'h0, ~s[3:0]} + {4'h0, ~f[FLG_C]};
        nf[FLG_V] = (op[7:4] == 4'h3) ? (d[7] != s[7]) && (r[7] == s[7]) : d[7] ^ r[7];
        nf[FLG_D] = (op[7:4] == 4'h3) ? 1'h1 : f[FLG_D];
        nf[FLG_H] = (op[7:4] == 4'h3) ? ~lo[4] : f[FLG_H];
        {nf[FLG_C], nf[FLG_Z], nf[FLG_S]} = {c, r == 8'h00, r[7]};
        if (op[3:0] == 4'hF) nf = {f[7:1], op[4]};
        return {r, nf};
    endfunction : expect_op
    task automatic exec(input logic [7:0] op, a1, a2, fl);
        logic [7:0]  da;
        logic [7:0]  sa;
        logic [7:0]  s;
        logic [15:0] e;
        int          n;
        int          w0;
        reg_wr(REG_FLAGS, fl);
        {da, sa} = {a1, a1};
        case (op)
            OP_RLC_IR, OP_RR_IR, OP_RRC_IR: da = rsbe_rf_model_inst.mem[a1];
            OP_SBC_WW: {da, sa} = {WREG_HI, a1[7:4], WREG_HI, a1[3:0]};
            OP_SBC_WI: {da, sa} = {WREG_HI, a1[7:4], rsbe_rf_model_inst.mem[{WREG_HI, a1[3:0]}]};
            OP_SBC_RR: da = a2;
            OP_SBC_RI: {da, sa} = {a2, rsbe_rf_model_inst.mem[a1]};
            default: ;
        endcase
        s = (op == OP_SBC_IM) ? a2 : rsbe_rf_model_inst.mem[sa];
        e = expect_op(op, rsbe_rf_model_inst.mem[da], s, fl);
        w0 = rsbe_rf_model_inst.wr_count;
        @(posedge clk_in);
        {start_in, instr_in} <= {1'h1, op, a1, a2};
        @(posedge clk_in);
        start_in <= 1'h0;
        n = 0;
        #1;
        while (n < 10 && done_out !== 1'h1) begin
            @(posedge clk_in);
            #1 n++;
        end
        `CHK(n, (op inside {[OP_SBC_WI:OP_SBC_IM]}) ? 6 : 4)
        `CHK(flags_out, e[7:0])
        @(posedge clk_in);
        #1;
        `CHK(rsbe_rf_model_inst.wr_count - w0, (op[3:0] == 4'hF) ? 0 : 1)
        if (op[3:0] != 4'hF) `CHK(rsbe_rf_model_inst.mem[da], e[15:8])
        if (op[7:4] == 4'h3 && op != OP_SBC_IM && sa != da) `CHK(rsbe_rf_model_inst.mem[sa], s)
        $display("test op %h done", op);
    endtask : exec
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        miscompares++;
        wrap_up();
    end
    initial begin
        {rst_b_in, start_in, instr_in, reg_addr_in, reg_wdata_in, reg_wr_in, reg_rd_in} = '0;
        repeat (5) @(posedge clk_in);
        rst_b_in <= 1'h1;
        #1 `CHK({flags_out, busy_out, done_out}, {FLAGS_RST, 2'h0})
        reg_rd(8'h55, rd_v);
        `CHK(rd_v, 8'h00)
        reg_wr(REG_STATUS, 8'hFF);
        reg_rd(REG_STATUS, rd_v);
        `CHK(rd_v, 8'h00)
        reg_wr(REG_FLAGS, 8'hA6);
        reg_rd(REG_FLAGS, rd_v);
        `CHK(rd_v, 8'hA6)
        // Plain rotate left is not ours: must be ignored
        @(posedge clk_in);
        {start_in, instr_in} <= {1'h1, 8'h90, 16'h2000};
        @(posedge clk_in);
        start_in <= 1'h0;
        repeat (5) @(posedge clk_in);
        #1 `CHK({busy_out, done_out}, 2'h0)
        $display("test register port done");
        rsbe_rf_model_inst.mem[8'h20] = 8'hAA;
        exec(OP_RLC_R, 8'h20, 8'h00, 8'h00);
        rsbe_rf_model_inst.mem[8'h20] = 8'h80;
        exec(OP_RLC_R, 8'h20, 8'h00, 8'h80);
        exec(OP_RLC_IR, 8'h21, 8'h00, 8'h8C);
        rsbe_rf_model_inst.mem[8'h30] = 8'h31;
        exec(OP_RR_R, 8'h30, 8'h00, 8'h0C);
        exec(OP_RR_IR, 8'h31, 8'h00, 8'h80);
        rsbe_rf_model_inst.mem[8'h40] = 8'h01;
        exec(OP_RRC_R, 8'h40, 8'h00, 8'h00);
        exec(OP_RRC_IR, 8'h41, 8'h00, 8'hFF);
        {rsbe_rf_model_inst.mem[8'hC1], rsbe_rf_model_inst.mem[8'hC2]} = 16'h1003;
        exec(OP_SBC_WW, 8'h12, 8'h00, 8'h80);
        rsbe_rf_model_inst.mem[8'h03] = 8'h0A;
        exec(OP_SBC_WI, 8'h12, 8'h00, 8'h80);
        {rsbe_rf_model_inst.mem[8'h01], rsbe_rf_model_inst.mem[8'h02]} = 16'h2003;
        exec(OP_SBC_RR, 8'h02, 8'h01, 8'h80);
        rsbe_rf_model_inst.mem[8'h01] = 8'h20;
        exec(OP_SBC_RI, 8'h02, 8'h01, 8'h80);
        exec(OP_SBC_IM, 8'h01, 8'h8A, 8'h80);
        rsbe_rf_model_inst.mem[8'h01] = 8'h05;
        exec(OP_SBC_IM, 8'h01, 8'h05, 8'h00);
        rsbe_rf_model_inst.mem[8'h01] = 8'h80;
        exec(OP_SBC_IM, 8'h01, 8'h01, 8'h00);
        exec(OP_SB_LOW, 8'h00, 8'h00, 8'hFF);
        exec(OP_SB_HIGH, 8'h00, 8'h00, 8'h00);
        wrap_up();
    end
endmodule : rsbe_exec_test
